// >>> common/spd_pkg.sv
// How it works
// - position readable, six bits, updates per step
// - direction is pin XOR polarity bit
// - positive direction counts position upward
// - direction works while motor disabled
// - direction and run/hold pin levels readable
// - pin rising edge or software bit steps
// - software step bit self-clears, even when hold or lockout blocks the step
// - simultaneous pin and software triggers: two steps
// - software step uses newly written direction
// - run mode is pin XOR polarity bit
// - run mode steps, uses run current code
// - hold ignores triggers, uses hold code
// - decode codes to peak milliamps, hold shifted
// - zero hold current disables detection, duty zero
// - current code change applies next period
// - enable gates bridges only, logic keeps working
// - latch five-bit back-emf code, report it
// - compare sample at zero crossing end
// - timeout forces compare, zero code disables
// - two low samples: stall, backstep, error
// - read clears stall; wait direction change
// - hold full-step motion check sets stall
// - threshold codes decode, zero disables
// - translator reset puts position at eight
package spd_pkg;
	localparam logic [7:0]  ADDR_CTRL     = 8'h00;
	localparam logic [7:0]  ADDR_STATUS   = 8'h04;
	localparam logic [7:0]  ADDR_CURRENT  = 8'h08;
	localparam int          CTRL_MOTOR_ENABLE_BIT    = 0;
	localparam int          CTRL_DIRECTION_POLARITY_BIT     = 1;
	localparam int          CTRL_SWSTEP   = 2;
	localparam int          CTRL_RUN_HOLD_POLARITY_BIT     = 3;
	localparam int          CTRL_TRRESET  = 4;
	localparam int          CTRL_IRUN     = 8;
	localparam int          CTRL_IHOLD    = 12;
	localparam int          CTRL_THR      = 16;
	localparam int          CTRL_TO       = 24;
	localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
	localparam logic [31:0] CTRL_WMASK    = 32'hFFFF_FF1F;
	localparam int          ST_DIR        = 6;
	localparam int          ST_RH         = 7;
	localparam int          ST_STALL      = 8;
	localparam int          ST_RUN        = 9;
	localparam int          ST_LOCK       = 10;
	localparam int          ST_BEMF       = 16;
	localparam int          CUR_CODE      = 12;
	localparam int          CUR_RUN       = 16;
	localparam int          CUR_DUTY0     = 17;
	localparam logic [5:0]  POS_RESET     = 6'h08;
	localparam logic [5:0]  POS_BACKSTEP  = 6'h18;
	localparam logic [1:0]  LOW_LIMIT     = 2'h2;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	typedef logic [3:0] spd_code_t;

	function automatic logic [8:0] spd_run_ma(input spd_code_t code);
		case (code)
			4'h0:    spd_run_ma = 9'h00F;
			4'h1:    spd_run_ma = 9'h01B;
			4'h2:    spd_run_ma = 9'h030;
			4'h3:    spd_run_ma = 9'h057;
			4'h4:    spd_run_ma = 9'h064;
			4'h5:    spd_run_ma = 9'h073;
			4'h6:    spd_run_ma = 9'h084;
			4'h7:    spd_run_ma = 9'h098;
			4'h8:    spd_run_ma = 9'h0AE;
			4'h9:    spd_run_ma = 9'h0C8;
			4'hA:    spd_run_ma = 9'h0E6;
			default: spd_run_ma = 9'h12C;
		endcase
	endfunction

	function automatic logic [8:0] spd_peak_ma(input logic run, input spd_code_t code);
		if (run)
			spd_peak_ma = spd_run_ma(code);
		else if (code == 4'h0)
			spd_peak_ma = 9'h000;
		else
			spd_peak_ma = spd_run_ma(code - 4'h1);
	endfunction

	// threshold in back-emf code units, about 8.3 codes per volt
	function automatic logic [4:0] spd_thr_level(input spd_code_t code);
		case (code)
			4'h7:    spd_thr_level = 5'h08;
			4'h8:    spd_thr_level = 5'h0A;
			4'h9:    spd_thr_level = 5'h0C;
			4'hA:    spd_thr_level = 5'h0F;
			4'hB:    spd_thr_level = 5'h11;
			4'hC:    spd_thr_level = 5'h13;
			4'hD:    spd_thr_level = 5'h15;
			4'hE:    spd_thr_level = 5'h17;
			4'hF:    spd_thr_level = 5'h19;
			default: spd_thr_level = {1'b0, code};
		endcase
	endfunction

	function automatic logic [31:0] spd_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
		for (int i = 0; i < 4; i++)
			spd_merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
	endfunction
endpackage

// >>> design/spd_positioner.sv
// Local design decisions: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
module spd_positioner
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        step_input,
	input  wire logic        direction_input,
	input  wire logic        run_hold_input,
	input  wire logic        pwm_period_start,
	input  wire logic        zero_cross_active,
	input  wire logic        bemf_valid,
	input  wire logic [4:0]  bemf_code,
	output logic [5:0]       position_field,
	output logic [3:0]       coil_current_code,
	output logic [8:0]       coil_peak_ma,
	output logic             coil_run_mode,
	output logic             duty_zero,
	output logic             detect_enable,
	output logic             bridge_enable,
	output logic             error_output_o,
	output logic             error_output_oe_n
);

////////////////////////////////////////////////////////////////////////////////
// register bus

logic        aw_held_q;
logic [7:0]  awaddr_q;
logic        w_held_q;
logic [31:0] wdata_q;
logic [3:0]  wstrb_q;
logic        bvalid_q;
logic [1:0]  bresp_q;
logic        rvalid_q;
logic [31:0] rdata_q;
logic [1:0]  rresp_q;
logic [31:0] ctrl_q;
logic [31:0] ctrl_d;

wire         aw_take    = s_axi_awvalid & s_axi_awready;
wire         w_take     = s_axi_wvalid & s_axi_wready;
wire         ar_take    = s_axi_arvalid & s_axi_arready;
wire         do_write   = aw_held_q & w_held_q & ~bvalid_q;
wire         wr_ctrl    = do_write & (awaddr_q == spd_pkg::ADDR_CTRL);
wire         wr_known   = wr_ctrl | (awaddr_q == spd_pkg::ADDR_STATUS) | (awaddr_q == spd_pkg::ADDR_CURRENT);
wire         rd_ctrl    = s_axi_araddr == spd_pkg::ADDR_CTRL;
wire         rd_status  = s_axi_araddr == spd_pkg::ADDR_STATUS;
wire         rd_current = s_axi_araddr == spd_pkg::ADDR_CURRENT;
wire         rd_known   = rd_ctrl | rd_status | rd_current;

assign s_axi_awready = ~aw_held_q & ~bvalid_q;
assign s_axi_wready  = ~w_held_q & ~bvalid_q;
assign s_axi_arready = ~rvalid_q;
assign s_axi_bvalid  = bvalid_q;
assign s_axi_bresp   = bresp_q;
assign s_axi_rvalid  = rvalid_q;
assign s_axi_rdata   = rdata_q;
assign s_axi_rresp   = rresp_q;

always_ff @(posedge clk or negedge rst_n)
begin
	if (!rst_n)
	begin
		aw_held_q <= 1'b0;
		awaddr_q  <= 8'h00;
		w_held_q  <= 1'b0;
		wdata_q   <= 32'h0000_0000;
		wstrb_q   <= 4'h0;
		bvalid_q  <= 1'b0;
		bresp_q   <= spd_pkg::RESP_OKAY;
	end
	else
	begin
		if (aw_take)
		begin
			aw_held_q <= 1'b1;
			awaddr_q  <= s_axi_awaddr;
		end
		if (w_take)
		begin
			w_held_q <= 1'b1;
			wdata_q  <= s_axi_wdata;
			wstrb_q  <= s_axi_wstrb;
		end
		if (do_write)
		begin
			aw_held_q <= 1'b0;
			w_held_q  <= 1'b0;
			bvalid_q  <= 1'b1;
			bresp_q   <= wr_known ? spd_pkg::RESP_OKAY : spd_pkg::RESP_SLVERR;
		end
		else if (bvalid_q & s_axi_bready)
			bvalid_q <= 1'b0;
	end
end

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers and mode decode

logic       step_s1_q, step_s2_q, step_s3_q;
logic       dir_s1_q, dir_s2_q;
logic       rh_s1_q, rh_s2_q;
logic       dir_eff_q;
logic [5:0] pos_q;
logic [5:0] pos_d;
logic       stall_q;
logic       lockout_q;
logic       stall_back;
logic       hold_move;

always_ff @(posedge clk or negedge rst_n)
begin
	if (!rst_n)
	begin
		step_s1_q <= 1'b0;
		step_s2_q <= 1'b0;
		step_s3_q <= 1'b0;
		dir_s1_q  <= 1'b0;
		dir_s2_q  <= 1'b0;
		rh_s1_q   <= 1'b0;
		rh_s2_q   <= 1'b0;
	end
	else
	begin
		step_s1_q <= step_input;
		step_s2_q <= step_s1_q;
		step_s3_q <= step_s2_q;
		dir_s1_q  <= direction_input;
		dir_s2_q  <= dir_s1_q;
		rh_s1_q   <= run_hold_input;
		rh_s2_q   <= rh_s1_q;
	end
end

// motor enable is deliberately absent from the stepping path
wire dir_eff    = dir_s2_q ^ ctrl_q[spd_pkg::CTRL_DIRECTION_POLARITY_BIT];
wire run_mode   = rh_s2_q ^ ctrl_q[spd_pkg::CTRL_RUN_HOLD_POLARITY_BIT];
wire pin_step   = step_s2_q & ~step_s3_q;
wire sw_req     = ctrl_q[spd_pkg::CTRL_SWSTEP];
wire step_ok    = run_mode & ~lockout_q;
wire pin_take   = pin_step & step_ok;
wire sw_take    = sw_req & step_ok & ~pin_step;
// a software step that meets a pin edge waits one cycle
wire sw_clear   = sw_req & ~pin_take;
wire step_now   = pin_take | sw_take;
wire tr_reset   = ctrl_q[spd_pkg::CTRL_TRRESET];
wire [5:0] step_delta = dir_eff ? 6'h01 : 6'h3F;
wire [5:0] back_delta = dir_eff ? (6'h00 - spd_pkg::POS_BACKSTEP) : spd_pkg::POS_BACKSTEP;

always_comb
begin
	ctrl_d = ctrl_q;
	if (sw_clear)
		ctrl_d[spd_pkg::CTRL_SWSTEP] = 1'b0;
	if (tr_reset)
		ctrl_d[spd_pkg::CTRL_TRRESET] = 1'b0;
	if (wr_ctrl)
		ctrl_d = spd_pkg::spd_merge(ctrl_q, wdata_q, wstrb_q) & spd_pkg::CTRL_WMASK;
end

// six-bit arithmetic wraps around the table circle
always_comb
begin
	pos_d = pos_q;
	if (tr_reset)
		pos_d = spd_pkg::POS_RESET;
	else if (stall_back)
		pos_d = pos_q + back_delta;
	else if (step_now)
		pos_d = pos_q + step_delta;
end

always_ff @(posedge clk or negedge rst_n)
begin
	if (!rst_n)
	begin
		ctrl_q    <= spd_pkg::CTRL_RESET;
		pos_q     <= spd_pkg::POS_RESET;
		dir_eff_q <= 1'b0;
	end
	else
	begin
		ctrl_q    <= ctrl_d;
		pos_q     <= pos_d;
		dir_eff_q <= dir_eff;
	end
end

////////////////////////////////////////////////////////////////////////////////
// current selection and stall detection

logic [3:0] applied_code_q;
logic       applied_run_q;
logic       duty_zero_q;
logic       detect_en_q;
logic       zc_d1_q;
logic [4:0] bemf_last_q;
logic [1:0] low_cnt_q;
logic [9:0] to_cnt_q;
logic       err_oe_n_q;

wire [3:0] run_code   = ctrl_q[spd_pkg::CTRL_IRUN +: 4];
wire [3:0] hold_code  = ctrl_q[spd_pkg::CTRL_IHOLD +: 4];
wire [3:0] thr_code   = ctrl_q[spd_pkg::CTRL_THR +: 4];
wire [7:0] to_code    = ctrl_q[spd_pkg::CTRL_TO +: 8];
wire [3:0] sel_code   = run_mode ? run_code : hold_code;
wire [4:0] thr_level  = spd_pkg::spd_thr_level(thr_code);
wire       thr_on     = thr_code != 4'h0;
wire       hold_zero  = ~run_mode & (hold_code == 4'h0);
wire       det_en     = thr_on & ~hold_zero;
wire [9:0] to_limit   = {to_code, 2'b00};
wire       timeout_hit = (to_code != 8'h00) & pwm_period_start & ((to_cnt_q + 10'h001) == to_limit);
wire       zc_end     = zc_d1_q & ~zero_cross_active;
wire       compare    = zc_end | timeout_hit;
wire       run_check  = compare & run_mode & thr_on;
wire       bemf_low   = bemf_last_q < thr_level;
wire       stall_clr  = ar_take & rd_status;
wire       stall_set  = stall_back | hold_move;
wire       full_step  = pos_q[3:0] == 4'h0;

assign stall_back = run_check & bemf_low & (low_cnt_q == (spd_pkg::LOW_LIMIT - 2'h1));
assign hold_move  = bemf_valid & ~run_mode & det_en & full_step & (bemf_code > thr_level);

always_ff @(posedge clk or negedge rst_n)
begin
	if (!rst_n)
	begin
		applied_code_q <= 4'h0;
		applied_run_q  <= 1'b0;
		duty_zero_q    <= 1'b1;
		detect_en_q    <= 1'b0;
	end
	else
	begin
		detect_en_q <= det_en;
		if (pwm_period_start)
		begin
			applied_code_q <= sel_code;
			applied_run_q  <= run_mode;
			duty_zero_q    <= hold_zero;
		end
	end
end

always_ff @(posedge clk or negedge rst_n)
begin
	if (!rst_n)
	begin
		zc_d1_q     <= 1'b0;
		bemf_last_q <= 5'h00;
		low_cnt_q   <= 2'h0;
		to_cnt_q    <= 10'h000;
	end
	else
	begin
		zc_d1_q <= zero_cross_active;
		if (bemf_valid)
			bemf_last_q <= bemf_code;
		if (!run_mode || stall_back || (run_check && !bemf_low))
			low_cnt_q <= 2'h0;
		else if (run_check)
			low_cnt_q <= low_cnt_q + 2'h1;
		if (step_now || timeout_hit || to_code == 8'h00)
			to_cnt_q <= 10'h000;
		else if (pwm_period_start)
			to_cnt_q <= to_cnt_q + 10'h001;
	end
end

// set wins over a clearing read in the same cycle
always_ff @(posedge clk or negedge rst_n)
begin
	if (!rst_n)
	begin
		stall_q    <= 1'b0;
		lockout_q  <= 1'b0;
		err_oe_n_q <= 1'b1;
	end
	else
	begin
		stall_q    <= stall_set | (stall_q & ~stall_clr);
		err_oe_n_q <= ~(stall_set | (stall_q & ~stall_clr));
		if (stall_clr && stall_q)
			lockout_q <= 1'b1;
		else if (dir_eff != dir_eff_q)
			lockout_q <= 1'b0;
	end
end

////////////////////////////////////////////////////////////////////////////////
// read path and outputs

wire [31:0] status_word = {11'h000, bemf_last_q, 5'h00, lockout_q, run_mode, stall_q,
	rh_s2_q, dir_s2_q, pos_q};
wire [31:0] current_word = {14'h0000, duty_zero_q, applied_run_q, applied_code_q,
	3'h0, spd_pkg::spd_peak_ma(applied_run_q, applied_code_q)};
wire [31:0] rd_mux = rd_ctrl ? ctrl_q : rd_status ? status_word : rd_current ? current_word : 32'h0000_0000;

always_ff @(posedge clk or negedge rst_n)
begin
	if (!rst_n)
	begin
		rvalid_q <= 1'b0;
		rdata_q  <= 32'h0000_0000;
		rresp_q  <= spd_pkg::RESP_OKAY;
	end
	else if (ar_take)
	begin
		rvalid_q <= 1'b1;
		rdata_q  <= rd_mux;
		rresp_q  <= rd_known ? spd_pkg::RESP_OKAY : spd_pkg::RESP_SLVERR;
	end
	else if (rvalid_q && s_axi_rready)
		rvalid_q <= 1'b0;
end

assign position_field    = pos_q;
assign coil_current_code = applied_code_q;
assign coil_peak_ma      = current_word[8:0];
assign coil_run_mode     = applied_run_q;
assign duty_zero         = duty_zero_q;
assign detect_enable     = detect_en_q;
assign bridge_enable     = ctrl_q[spd_pkg::CTRL_MOTOR_ENABLE_BIT];
assign error_output_o    = 1'b0;
assign error_output_oe_n = err_oe_n_q;

////////////////////////////////////////////////////////////////////////////////
// checks

default clocking chk_cb @(posedge clk);
endclocking
default disable iff (!rst_n);

chk_step_position_up: assert property (
	step_now && dir_eff && !stall_back && !tr_reset |=> pos_q == $past(pos_q) + 6'h01)
	else $error("position did not advance on step");

chk_dir_xor_down: assert property (
	pin_take && !(dir_s2_q ^ ctrl_q[spd_pkg::CTRL_DIRECTION_POLARITY_BIT]) && !stall_back && !tr_reset
	|=> pos_q == $past(pos_q) - 6'h01)
	else $error("down step not taken for cleared direction");

chk_hold_keeps_pos: assert property (
	!run_mode && !stall_back && !tr_reset |=> pos_q == $past(pos_q))
	else $error("position moved in hold");

chk_sw_step_clears: assert property (
	sw_req && step_ok && !pin_step && !wr_ctrl |=> !ctrl_q[spd_pkg::CTRL_SWSTEP] && pos_q != $past(pos_q))
	else $error("software step not taken and cleared");

chk_two_triggers: assert property (
	pin_take && sw_req && !wr_ctrl |=> sw_req ##0 (sw_take || !step_ok || stall_back))
	else $error("software step lost against pin edge");

chk_current_next_period: assert property (
	!pwm_period_start |=> applied_code_q == $past(applied_code_q))
	else $error("current code changed outside period start");

chk_stall_backstep: assert property (
	stall_back && !tr_reset |=> stall_q && !error_output_oe_n && pos_q == $past(pos_q) + $past(back_delta))
	else $error("stall backstep or error missing");

chk_clear_then_lock: assert property (
	stall_clr && stall_q && !stall_set |=> !stall_q && error_output_oe_n && lockout_q)
	else $error("stall read did not clear and lock");

chk_zero_threshold_off: assert property (
	thr_code == 4'h0 |-> !stall_set)
	else $error("stall raised with detection disabled");

chk_zero_hold_quiet: assert property (
	hold_zero |-> !hold_move ##1 !detect_enable)
	else $error("detection active at zero hold current");

chk_timeout_count: assert property (
	timeout_hit |-> to_code != 8'h00 ##1 to_cnt_q == 10'h000)
	else $error("timeout compare fired wrongly");

cov_stall_run:   cover property (stall_back);
cov_hold_motion: cover property (hold_move);
cov_both_steps:  cover property (pin_take && sw_req ##1 sw_take);
cov_timeout:     cover property (timeout_hit && run_check);

endmodule // spd_positioner

// >>> sim/spd_mcu.sv
`timescale 1ns/1ps
module spd_mcu
(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic go,
	input  wire logic dir_set,
	input  wire logic rh_set,
	output logic      step_input,
	output logic      direction_input,
	output logic      run_hold_input,
	output logic      busy
);
	logic [3:0] cnt_q;
	logic       step_d;

	// step pulse only after direction has settled four cycles
	assign step_d = (cnt_q >= 4'h4) && (cnt_q < 4'h8);

	////////////////////////////////////////////////////////////
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_q <= 4'h0;
			busy <= 1'b0;
			step_input <= 1'b0;
			direction_input <= 1'b0;
			run_hold_input <= 1'b0;
		end
		else
		begin
			run_hold_input <= rh_set;
			if (go && !busy)
			begin
				direction_input <= dir_set;
				cnt_q <= 4'h0;
				busy <= 1'b1;
			end
			else if (busy)
			begin
				cnt_q <= cnt_q + 4'h1;
				step_input <= step_d;
				busy <= (cnt_q != 4'hB);
			end
		end
	end
endmodule // spd_mcu

// >>> sim/tb.sv
`timescale 1ns/1ps
module tb;
	typedef struct {logic [31:0] ctrl; logic rh; logic run; logic [8:0] ma; logic dz;} spd_row_t;
	logic        clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb, coil_current_code;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic        step_input, direction_input, run_hold_input, pwm_period_start, zero_cross_active;
	logic        bemf_valid, coil_run_mode, duty_zero, detect_enable, bridge_enable;
	logic        error_output_o, error_output_oe_n, mgo, mdir, mrh, mbusy;
	logic [4:0]  bemf_code;
	logic [5:0]  position_field;
	logic [8:0]  coil_peak_ma;
	int          fails, cmp_count;
	spd_row_t    rows [6] = '{'{32'h0000_0000, 1'b1, 1'b1, 9'h00F, 1'b0}, '{32'h0000_0B00, 1'b1, 1'b1, 9'h12C, 1'b0},
		'{32'h0000_0B08, 1'b1, 1'b0, 9'h000, 1'b1}, '{32'h0000_1000, 1'b0, 1'b0, 9'h00F, 1'b0},
		'{32'h0000_B000, 1'b0, 1'b0, 9'h0E6, 1'b0}, '{32'h0000_0508, 1'b0, 1'b1, 9'h073, 1'b0}};

	spd_positioner uut (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .step_input, .direction_input,
		.run_hold_input, .pwm_period_start, .zero_cross_active, .bemf_valid, .bemf_code, .position_field,
		.coil_current_code, .coil_peak_ma, .coil_run_mode, .duty_zero, .detect_enable, .bridge_enable,
		.error_output_o, .error_output_oe_n);
	spd_mcu mcu (.clk, .rst_n, .go(mgo), .dir_set(mdir), .rh_set(mrh), .step_input, .direction_input,
		.run_hold_input, .busy(mbusy));

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
		int   n;
		logic ta, tw, tk;
		n = 0;
		tk = 1'b0;
		rs = 2'h3;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!tk && n < 50)
		begin
			@(negedge clk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			tk = s_axi_bvalid;
			rs = s_axi_bresp;
			@(posedge clk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (tk) s_axi_bready <= 1'b0;
			n++;
		end
		if (!tk) fails++;
		if (!tk) report_and_stop();
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		int   n;
		logic ta, tk;
		logic [31:0] d;
		n = 0;
		tk = 1'b0;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!tk && n < 50)
		begin
			@(negedge clk);
			ta = s_axi_arvalid && s_axi_arready;
			tk = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge clk);
			if (ta) s_axi_arvalid <= 1'b0;
			if (tk) s_axi_rready <= 1'b0;
			n++;
		end
		if (!tk) fails++;
		if (!tk) report_and_stop();
		chk("rdata", e, d);
		chk("rresp", 32'(er), 32'(r));
	endtask

	task automatic mstep(input logic d);
		int n;
		n = 0;
		@(posedge clk);
		mgo <= 1'b1;
		mdir <= d;
		@(posedge clk);
		mgo <= 1'b0;
		cyc(2);
		while (mbusy && n < 40)
		begin
			@(posedge clk);
			n++;
		end
		if (mbusy) fails++;
		if (mbusy) report_and_stop();
		cyc(6);
	endtask

	task automatic pwm();
		@(posedge clk);
		pwm_period_start <= 1'b1;
		@(posedge clk);
		pwm_period_start <= 1'b0;
	endtask

	// one zero crossing with one back-emf sample inside it
	task automatic zc(input logic [4:0] c);
		@(posedge clk);
		zero_cross_active <= 1'b1;
		bemf_valid <= 1'b1;
		bemf_code <= c;
		@(posedge clk);
		bemf_valid <= 1'b0;
		@(posedge clk);
		zero_cross_active <= 1'b0;
		cyc(3);
	endtask

	task automatic wr(input logic [31:0] d);
		axi_wr(spd_pkg::ADDR_CTRL, d, r);
		cyc(3);
	endtask

	////////////////////////////////////////////////////////////
	initial
	begin
		{rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, mgo, mdir, mrh} = 9'h000;
		{pwm_period_start, zero_cross_active, bemf_valid, bemf_code, s_axi_awaddr, s_axi_araddr} = 24'h0;
		s_axi_wdata = 32'h0000_0000;
		s_axi_wstrb = 4'hF;
		fails = 0;
		cmp_count = 0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		cyc(4);
		for (int i = 0; i < 6; i++)
		begin
			mrh <= rows[i].rh;
			wr(rows[i].ctrl);
			if (i > 0) chk("peak_held", 32'(rows[i-1].ma), 32'(coil_peak_ma));
			pwm();
			cyc(2);
			chk("peak", 32'(rows[i].ma), 32'(coil_peak_ma));
			chk("run_mode", 32'(rows[i].run), 32'(coil_run_mode));
			chk("duty_zero", 32'(rows[i].dz), 32'(duty_zero));
			chk("code", 32'(rows[i].run ? rows[i].ctrl[11:8] : rows[i].ctrl[15:12]),
				32'(coil_current_code));
			$display("row %0d done", i);
		end
		rdc(spd_pkg::ADDR_CURRENT, 32'h0001_5073, spd_pkg::RESP_OKAY);
		@(posedge clk);
		rst_n <= 1'b0;
		mrh <= 1'b1;
		cyc(3);
		rst_n <= 1'b1;
		cyc(4);
		chk("position", 32'h8, 32'(position_field));
		chk("err_oe_n", 32'h1, 32'(error_output_oe_n));
		rdc(spd_pkg::ADDR_CTRL, spd_pkg::CTRL_RESET, spd_pkg::RESP_OKAY);
		rdc(8'h0C, 32'h0, spd_pkg::RESP_SLVERR);
		axi_wr(spd_pkg::ADDR_STATUS, 32'h3F, r);
		chk("bresp", 32'(spd_pkg::RESP_OKAY), 32'(r));
		$display("reset test done");
		mstep(1'b1);
		chk("position", 32'h9, 32'(position_field));
		mstep(1'b0);
		chk("position", 32'h8, 32'(position_field));
		wr(32'h6);
		chk("position", 32'h9, 32'(position_field));
		rdc(spd_pkg::ADDR_CTRL, 32'h2, spd_pkg::RESP_OKAY);
		chk("bridge", 32'h0, 32'(bridge_enable));
		fork
			mstep(1'b0);
			axi_wr(spd_pkg::ADDR_CTRL, 32'h6, r);
		join
		cyc(4);
		chk("position", 32'hB, 32'(position_field));
		rdc(spd_pkg::ADDR_STATUS, 32'h0000_028B, spd_pkg::RESP_OKAY);
		$display("step test done");
		wr(32'h10);
		chk("position", 32'h8, 32'(position_field));
		repeat (8) wr(32'h4);
		chk("position", 32'h0, 32'(position_field));
		wr(32'h4);
		chk("position", 32'h3F, 32'(position_field));
		wr(32'h6);
		chk("position", 32'h0, 32'(position_field));
		$display("wrap test done");
		mrh <= 1'b0;
		wr(32'h0001_0000);
		mstep(1'b1);
		chk("position", 32'h0, 32'(position_field));
		pwm();
		cyc(2);
		chk("detect", 32'h0, 32'(detect_enable));
		zc(5'h05);
		chk("err_oe_n", 32'h1, 32'(error_output_oe_n));
		wr(32'h0001_1000);
		pwm();
		cyc(2);
		chk("detect", 32'h1, 32'(detect_enable));
		zc(5'h05);
		chk("err_oe_n", 32'h0, 32'(error_output_oe_n));
		rdc(spd_pkg::ADDR_STATUS, 32'h0005_0140, spd_pkg::RESP_OKAY);
		cyc(2);
		chk("err_oe_n", 32'h1, 32'(error_output_oe_n));
		mrh <= 1'b1;
		wr(32'h0001_0000);
		mstep(1'b1);
		chk("position", 32'h0, 32'(position_field));
		mstep(1'b0);
		chk("position", 32'h3F, 32'(position_field));
		$display("hold test done");
		wr(32'h0001_0B00);
		pwm();
		zc(5'h00);
		chk("err_oe_n", 32'h1, 32'(error_output_oe_n));
		zc(5'h00);
		chk("err_oe_n", 32'h0, 32'(error_output_oe_n));
		chk("err_o", 32'h0, 32'(error_output_o));
		chk("position", 32'h17, 32'(position_field));
		chk("run_mode", 32'h1, 32'(coil_run_mode));
		rdc(spd_pkg::ADDR_STATUS, 32'h0000_0397, spd_pkg::RESP_OKAY);
		wr(32'h0000_0B00);
		zc(5'h00);
		zc(5'h00);
		chk("err_oe_n", 32'h1, 32'(error_output_oe_n));
		wr(32'h0001_0B00);
		repeat (12) pwm();
		chk("err_oe_n", 32'h1, 32'(error_output_oe_n));
		wr(32'h0101_0B00);
		repeat (12) pwm();
		cyc(2);
		chk("err_oe_n", 32'h0, 32'(error_output_oe_n));
		wr(32'h0000_0001);
		chk("bridge", 32'h1, 32'(bridge_enable));
		$display("stall test done");
		report_and_stop();
	end
endmodule // tb
